/* File: rtl/crcs_core_regs.sv */
/*
 * Programmer-visible register set of the 8-bit core: accumulator, pointer and
 * short-direct registers on the data space, program counter, three banked
 * carry/zero pairs and a six-level return stack.
 * Assumes the decoder drives one program counter command and one flag command
 * per machine cycle, and that clk is the machine-cycle clock.
 */
`timescale 1ns/10ps
`include "crcs_params.svh"

module crcs_core_regs #(
    parameter int STACK_DEPTH = `CRCS_STACK_DEPTH
) (
    input wire logic clk, // Machine-cycle clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [7:0] ds_addr, // Data-space address.
    input wire logic ds_wr, // Data-space write strobe.
    input wire logic ds_rd, // Data-space read strobe.
    input wire logic [7:0] ds_wdata, // Data-space write data.
    output logic [7:0] ds_rdata, // Read data, one cycle after ds_rd.
    output logic ds_hit, // Read address belonged to this block.
    input wire logic acc_we, // Core writes an ALU result to the accumulator.
    input wire logic [7:0] acc_wdata, // ALU result for the accumulator.
    input wire crcs_pkg::crcs_pc_cmd_type pc_cmd, // Program counter command.
    input wire crcs_pkg::crcs_flag_cmd_type flag_cmd, // Flag update request.
    output logic [11:0] pc, // Next program-space fetch address.
    output logic [7:0] acc, // Accumulator contents.
    output logic carry, // Active carry flag.
    output logic zero, // Active zero flag.
    output logic [7:0] rotl_result, // Accumulator rotated left through carry.
    output crcs_pkg::crcs_ctx_type ctx, // Active execution context.
    output logic [2:0] stack_level // Number of valid stack levels.
);

    logic [7:0] acc_q;
    logic [7:0] ptr_one_q;
    logic [7:0] ptr_second_q;
    logic [7:0] sd_one_q;
    logic [7:0] sd_second_q;
    logic [7:0] rdata_q;
    logic hit_q;
    logic [11:0] pc_q;
    logic [11:0] pc_d;
    logic [11:0] stack_q [STACK_DEPTH];
    logic [2:0] depth_q;
    logic [2:0] depth_d;
    logic [2:0] carry_q;
    logic [2:0] zero_q;
    crcs_pkg::crcs_ctx_type ctx_q;
    crcs_pkg::crcs_ctx_type ctx_d;
    crcs_pkg::crcs_ctx_type nmi_prev_q;

    // Sign-extend the branch offset and add it; the counter wraps in 12 bits.
    function automatic logic [11:0] pc_add(input logic [11:0] base, input logic [7:0] offs);
        pc_add = base + {{4{offs[7]}}, offs};
    endfunction

    // Index of the flag pair belonging to a context.
    function automatic logic [1:0] ctx_index(input crcs_pkg::crcs_ctx_type c);
        case (c)
            crcs_pkg::CTX_IRQ: ctx_index = 2'd1;
            crcs_pkg::CTX_NMI: ctx_index = 2'd2;
            default: ctx_index = 2'd0;
        endcase
    endfunction

    // Data-space decode.
    wire sel_acc = ds_addr == `CRCS_ADDR_ACC;
    wire sel_ptr_one = ds_addr == `CRCS_ADDR_PTR_ONE;
    wire sel_ptr_second = ds_addr == `CRCS_ADDR_PTR_SECOND;
    wire sel_sd_one = ds_addr == `CRCS_ADDR_SD_ONE;
    wire sel_sd_second = ds_addr == `CRCS_ADDR_SD_SECOND;
    wire sel_any = sel_acc | sel_ptr_one | sel_ptr_second | sel_sd_one | sel_sd_second;
    wire [7:0] rd_mux = sel_acc ? acc_q :
                        sel_ptr_one ? ptr_one_q :
                        sel_ptr_second ? ptr_second_q :
                        sel_sd_one ? sd_one_q :
                        sel_sd_second ? sd_second_q : `CRCS_RST_BYTE;

    // Command decode.
    wire is_push = pc_cmd.op == crcs_pkg::PC_CALL || pc_cmd.op == crcs_pkg::PC_IRQ ||
                   pc_cmd.op == crcs_pkg::PC_NMI;
    wire is_pop = pc_cmd.op == crcs_pkg::PC_RET;
    wire stack_empty = depth_q == 3'd0;
    wire [1:0] act = ctx_index(ctx_q);

    // Program counter next value.
    always_comb begin
        case (pc_cmd.op)
            crcs_pkg::PC_STEP: pc_d = pc_q + 12'h001;
            crcs_pkg::PC_REL: pc_d = pc_add(pc_q, pc_cmd.offset);
            crcs_pkg::PC_JUMP, crcs_pkg::PC_CALL,
            crcs_pkg::PC_IRQ, crcs_pkg::PC_NMI: pc_d = pc_cmd.target;
            // An empty stack gives nothing to pop, so the next instruction runs.
            crcs_pkg::PC_RET: pc_d = stack_empty ? pc_q + 12'h001 : stack_q[0];
            default: pc_d = pc_q;
        endcase
    end

    // Stack depth saturates at both ends instead of wrapping.
    assign depth_d = (is_push && depth_q != STACK_DEPTH[2:0]) ? depth_q + 3'd1 :
                     (is_pop && !stack_empty) ? depth_q - 3'd1 : depth_q;

    // Context change on entry and interrupt return.
    always_comb begin
        ctx_d = ctx_q;
        if (pc_cmd.op == crcs_pkg::PC_NMI) begin
            ctx_d = crcs_pkg::CTX_NMI;
        end else if (pc_cmd.op == crcs_pkg::PC_IRQ) begin
            ctx_d = crcs_pkg::CTX_IRQ;
        end else if (is_pop && pc_cmd.is_irq_back) begin
            case (ctx_q)
                crcs_pkg::CTX_NMI: ctx_d = nmi_prev_q;
                crcs_pkg::CTX_IRQ: ctx_d = crcs_pkg::CTX_NORMAL;
                default: ctx_d = crcs_pkg::CTX_NORMAL;
            endcase
        end
    end

    // Data-space registers; an ALU result wins over a bus write to the accumulator.
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= `CRCS_RST_BYTE;
            ptr_one_q <= `CRCS_RST_BYTE;
            ptr_second_q <= `CRCS_RST_BYTE;
            sd_one_q <= `CRCS_RST_BYTE;
            sd_second_q <= `CRCS_RST_BYTE;
        end else begin
            if (acc_we) begin
                acc_q <= acc_wdata;
            end else if (ds_wr && sel_acc) begin
                acc_q <= ds_wdata;
            end
            if (ds_wr && sel_ptr_one) begin
                ptr_one_q <= ds_wdata;
            end
            if (ds_wr && sel_ptr_second) begin
                ptr_second_q <= ds_wdata;
            end
            if (ds_wr && sel_sd_one) begin
                sd_one_q <= ds_wdata;
            end
            if (ds_wr && sel_sd_second) begin
                sd_second_q <= ds_wdata;
            end
        end
    end

    // Registered read port; unmapped addresses answer zero with no hit.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= `CRCS_RST_BYTE;
            hit_q <= 1'b0;
        end else begin
            rdata_q <= ds_rd ? rd_mux : `CRCS_RST_BYTE;
            hit_q <= ds_rd && sel_any;
        end
    end

    // Program counter, depth and context.
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_q <= `CRCS_RST_PC;
            depth_q <= 3'd0;
            ctx_q <= crcs_pkg::CTX_NMI;
            nmi_prev_q <= crcs_pkg::CTX_NORMAL;
        end else begin
            pc_q <= pc_d;
            depth_q <= depth_d;
            ctx_q <= ctx_d;
            if (pc_cmd.op == crcs_pkg::PC_NMI) begin
                nmi_prev_q <= ctx_q;
            end
        end
    end

    // Shift stack: no pointer, levels move as a whole; the sixth falls off.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= `CRCS_RST_PC;
            end
        end else if (is_push) begin
            stack_q[0] <= pc_q;
            for (int i = 1; i < STACK_DEPTH; i++) begin
                stack_q[i] <= stack_q[i-1];
            end
        end else if (is_pop && !stack_empty) begin
            for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                stack_q[i] <= stack_q[i+1];
            end
            stack_q[STACK_DEPTH-1] <= `CRCS_RST_PC;
        end
    end

    // Banked flags: only the active pair changes, so the others keep their state.
    always_ff @(posedge clk) begin
        if (rst) begin
            carry_q <= 3'b000;
            zero_q <= 3'b000;
        end else begin
            case (flag_cmd.op)
                crcs_pkg::FL_ARITH: begin
                    carry_q[act] <= flag_cmd.carry;
                    zero_q[act] <= flag_cmd.result == 8'h00;
                end
                crcs_pkg::FL_LOGIC: begin
                    zero_q[act] <= flag_cmd.result == 8'h00;
                end
                crcs_pkg::FL_BITTEST: begin
                    carry_q[act] <= flag_cmd.tested_bit;
                end
                default: begin
                end
            endcase
        end
    end

    // Outputs come straight from flip-flops, except carry, zero and the rotate view, which select the active pair.
    assign ds_rdata = rdata_q;
    assign ds_hit = hit_q;
    assign pc = pc_q;
    assign acc = acc_q;
    assign carry = carry_q[act];
    assign zero = zero_q[act];
    assign rotl_result = {acc_q[6:0], carry_q[act]};
    assign ctx = ctx_q;
    assign stack_level = depth_q;

    // Assertions.
    step_adds_one_a: assert property (@(posedge clk) disable iff (rst)
        pc_cmd.op == crcs_pkg::PC_STEP |=> pc == $past(pc) + 12'h001)
        else $error("Step did not advance program counter by one.");

    rel_branch_sum_a: assert property (@(posedge clk) disable iff (rst)
        pc_cmd.op == crcs_pkg::PC_REL |=> pc == $past(pc) + {{4{$past(pc_cmd.offset[7])}}, $past(pc_cmd.offset)})
        else $error("Relative branch sum wrong.");

    call_then_ret_a: assert property (@(posedge clk) disable iff (rst)
        (pc_cmd.op == crcs_pkg::PC_CALL) ##1 (pc_cmd.op == crcs_pkg::PC_RET)
        |=> pc == $past(pc, 2) + 12'h000)
        else $error("Return did not restore the called-from address.");

    push_top_a: assert property (@(posedge clk) disable iff (rst)
        is_push |=> stack_q[0] == $past(pc) && stack_q[1] == $past(stack_q[0]))
        else $error("Push did not place counter in first level.");

    depth_sat_a: assert property (@(posedge clk) disable iff (rst)
        depth_q == STACK_DEPTH[2:0] && is_push |=> depth_q == STACK_DEPTH[2:0])
        else $error("Stack depth moved beyond its deepest position.");

    empty_ret_a: assert property (@(posedge clk) disable iff (rst)
        stack_empty && is_pop |=> depth_q == 3'd0 && pc == $past(pc) + 12'h001)
        else $error("Return on empty stack misbehaved.");

    reset_nmi_ctx_a: assert property (@(posedge clk)
        rst |=> ctx == crcs_pkg::CTX_NMI && carry == 1'b0 && zero == 1'b0)
        else $error("Reset did not select the cleared non-maskable pair.");

    irq_back_a: assert property (@(posedge clk) disable iff (rst)
        ctx == crcs_pkg::CTX_IRQ && pc_cmd.op == crcs_pkg::PC_RET && pc_cmd.is_irq_back
        |=> ctx == crcs_pkg::CTX_NORMAL)
        else $error("Interrupt return did not restore the normal context.");

    // A switch with no flag update in the same cycle must leave every pair as it was.
    flag_keep_a: assert property (@(posedge clk) disable iff (rst)
        ctx_q != $past(ctx_q) && $past(flag_cmd.op) == crcs_pkg::FL_NONE |->
        carry_q == $past(carry_q) && zero_q == $past(zero_q))
        else $error("Flag pair changed on a context switch.");

    zero_result_a: assert property (@(posedge clk) disable iff (rst)
        flag_cmd.op == crcs_pkg::FL_LOGIC && ctx_d == ctx_q |=> zero == ($past(flag_cmd.result) == 8'h00))
        else $error("Zero flag disagrees with last result.");

    acc_readback_a: assert property (@(posedge clk) disable iff (rst)
        ds_rd && sel_acc |=> ds_hit && ds_rdata == $past(acc_q))
        else $error("Accumulator read at FFh returned wrong data.");

    pop_level_a: assert property (@(posedge clk) disable iff (rst)
        is_pop && !stack_empty |=> stack_level == $past(stack_level) - 3'd1 && pc == $past(stack_q[0]))
        else $error("Return did not pop level one into the counter.");

    irq_entry_a: assert property (@(posedge clk) disable iff (rst)
        pc_cmd.op == crcs_pkg::PC_IRQ |=> ctx == crcs_pkg::CTX_IRQ && carry == $past(carry_q[1]))
        else $error("Interrupt entry did not select the interrupt pair.");

endmodule

/* File: rtl/crcs_params.svh */
/*
 * Offsets, reset values and widths for the core register set.
 * Assumes a single clock and an 8-bit data space with 8-bit addresses.
 */
`ifndef CRCS_PARAMS_SVH
`define CRCS_PARAMS_SVH

// Data-space addresses of the core registers.
`define CRCS_ADDR_PTR_ONE 8'h80
`define CRCS_ADDR_PTR_SECOND 8'h81
`define CRCS_ADDR_SD_ONE 8'h82
`define CRCS_ADDR_SD_SECOND 8'h83
`define CRCS_ADDR_ACC 8'hff

// Widths and sizes.
`define CRCS_DATA_W 8
`define CRCS_PC_W 12
`define CRCS_STACK_DEPTH 6
`define CRCS_DEPTH_W 3

// Reset values.
`define CRCS_RST_BYTE 8'h00
`define CRCS_RST_PC 12'h000

`endif

/* File: rtl/crcs_pkg.sv */
/*
 * Types shared by the core register set: program counter commands,
 * flag update requests and the execution context.
 * Assumes the instruction decoder issues at most one command per cycle.
 */
package crcs_pkg;

    // Program counter command, one-hot.
    typedef enum logic [7:0] {
        PC_HOLD = 8'h01,
        PC_STEP = 8'h02,
        PC_REL = 8'h04,
        PC_JUMP = 8'h08,
        PC_CALL = 8'h10,
        PC_IRQ = 8'h20,
        PC_NMI = 8'h40,
        PC_RET = 8'h80
    } crcs_pc_op_type;

    // Flag update kind, one-hot.
    typedef enum logic [3:0] {
        FL_NONE = 4'h1,
        FL_ARITH = 4'h2,
        FL_LOGIC = 4'h4,
        FL_BITTEST = 4'h8
    } crcs_flag_op_type;

    // Execution context, one-hot.
    typedef enum logic [2:0] {
        CTX_NORMAL = 3'h1,
        CTX_IRQ = 3'h2,
        CTX_NMI = 3'h4
    } crcs_ctx_type;

    typedef struct packed {
        crcs_pc_op_type op;
        logic is_irq_back;
        logic [11:0] target;
        logic [7:0] offset;
    } crcs_pc_cmd_type;

    typedef struct packed {
        crcs_flag_op_type op;
        logic carry;
        logic [7:0] result;
        logic tested_bit;
    } crcs_flag_cmd_type;

endpackage

/* File: dv/crcs_ds_master.sv */
/*
 * Data-space bus master standing where the core's instruction engine reaches the registers.
 * Assumes the bench calls its tasks one at a time and clk is the machine-cycle clock.
 */
`timescale 1ns/10ps
module crcs_ds_master (
    input wire logic clk, // Machine-cycle clock.
    output logic [7:0] ds_addr, // Data-space address.
    output logic ds_wr, // Write strobe.
    output logic ds_rd, // Read strobe.
    output logic [7:0] ds_wdata, // Write data.
    input wire logic [7:0] ds_rdata, // Registered read data.
    input wire logic ds_hit // Read belonged to the block.
);
    // Idle bus at time zero.
    initial begin
        ds_addr = 8'h00;
        ds_wdata = 8'h00;
        ds_wr = 1'b0;
        ds_rd = 1'b0;
    end

    // Held over one rising edge; the data is then inverted so a stale byte is never taken as held.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        ds_addr = a;
        ds_wdata = d;
        ds_wr = 1'b1;
        @(negedge clk);
        ds_wr = 1'b0;
        ds_wdata = ~d;
    endtask

    // The answer stands only in the cycle after the strobe edge, so it is taken there.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge clk);
        ds_addr = a;
        ds_rd = 1'b1;
        @(negedge clk);
        ds_rd = 1'b0;
        d = ds_rdata;
        h = ds_hit;
    endtask
endmodule

/* File: dv/cpu_register_context_stack_bench.sv */
/*
 * Self-checking bench for the core register set: data-space registers, program counter,
 * return stack and banked flags. Assumes the design package and the bus master model.
 */
`timescale 1ns/10ps
module cpu_register_context_stack_bench;
    logic clk, rst, ds_wr, ds_rd, ds_hit, acc_we, carry, zero, hitv;
    logic [7:0] ds_addr, ds_wdata, ds_rdata, acc_wdata, acc, rotl_result, rdv, saved;
    logic [11:0] pc;
    logic [2:0] stack_level;
    logic [7:0] regs [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
    crcs_pkg::crcs_pc_cmd_type pc_cmd;
    crcs_pkg::crcs_flag_cmd_type flag_cmd;
    crcs_pkg::crcs_ctx_type ctx;
    int errors, checks, cycles;

    crcs_core_regs u_dut (.clk(clk), .rst(rst), .ds_addr(ds_addr), .ds_wr(ds_wr), .ds_rd(ds_rd),
        .ds_wdata(ds_wdata), .ds_rdata(ds_rdata), .ds_hit(ds_hit), .acc_we(acc_we), .acc_wdata(acc_wdata),
        .pc_cmd(pc_cmd), .flag_cmd(flag_cmd), .pc(pc), .acc(acc), .carry(carry), .zero(zero),
        .rotl_result(rotl_result), .ctx(ctx), .stack_level(stack_level));

    crcs_ds_master u_bus (.clk(clk), .ds_addr(ds_addr), .ds_wr(ds_wr), .ds_rd(ds_rd), .ds_wdata(ds_wdata),
        .ds_rdata(ds_rdata), .ds_hit(ds_hit));

    // Clock of 100 ns period.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        checks = checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic final_report;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Commands stand for one edge, then a hold cycle follows so no signal is driven twice at once.
    task automatic pcop(input crcs_pkg::crcs_pc_op_type op, input logic ib, input logic [11:0] t,
        input logic [7:0] o);
        @(negedge clk);
        pc_cmd = '{op, ib, t, o};
        @(negedge clk);
        pc_cmd.op = crcs_pkg::PC_HOLD;
    endtask

    task automatic flop(input crcs_pkg::crcs_flag_op_type op, input logic c, input logic [7:0] r,
        input logic b);
        @(negedge clk);
        flag_cmd = '{op, c, r, b};
        @(negedge clk);
        flag_cmd.op = crcs_pkg::FL_NONE;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic eh);
        u_bus.rd(a, rdv, hitv);
        chk(rdv, e, "read data");
        chk(hitv, eh, "read hit");
    endtask

    task automatic flags(input logic c, input logic z, input crcs_pkg::crcs_ctx_type x);
        chk(carry, c, "carry");
        chk(zero, z, "zero");
        chk(ctx, x, "context");
    endtask

    // Hang guard: the sequence needs well under two hundred cycles.
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t run did not finish", $time);
            final_report;
        end
    end

    initial begin
        errors = 0;
        checks = 0;
        cycles = 0;
        rst = 1'b1;
        acc_we = 1'b0;
        acc_wdata = 8'h00;
        pc_cmd = '{crcs_pkg::PC_HOLD, 1'b0, 12'h000, 8'h00};
        flag_cmd = '{crcs_pkg::FL_NONE, 1'b0, 8'h00, 1'b0};
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk(pc, 12'h000, "pc after reset");
        chk(stack_level, 12'h000, "level after reset");
        flags(1'b0, 1'b0, crcs_pkg::CTX_NMI);
        for (int i = 0; i < 5; i++) rdchk(regs[i], 8'h00, 1'b1);
        // Every mapped byte keeps its own value; an unmapped write aliases nowhere.
        for (int i = 0; i < 5; i++) u_bus.wr(regs[i], 8'ha5 ^ 8'(i));
        u_bus.wr(8'h84, 8'h77);
        for (int i = 0; i < 5; i++) rdchk(regs[i], 8'ha5 ^ 8'(i), 1'b1);
        rdchk(8'h84, 8'h00, 1'b0);
        chk(acc, 8'ha1, "acc after bus write");
        // The result write and a bus write collide in one cycle.
        fork
            u_bus.wr(8'hff, 8'hc3);
            begin
                @(negedge clk);
                acc_we = 1'b1;
                acc_wdata = 8'h3c;
                @(negedge clk);
                acc_we = 1'b0;
            end
        join
        chk(acc, 8'h3c, "result write");
        pcop(crcs_pkg::PC_STEP, 1'b0, 12'h000, 8'h00);
        chk(pc, 12'h001, "step");
        pcop(crcs_pkg::PC_JUMP, 1'b0, 12'hfff, 8'h00);
        chk(pc, 12'hfff, "jump");
        pcop(crcs_pkg::PC_STEP, 1'b0, 12'h000, 8'h00);
        chk(pc, 12'h000, "wrap");
        pcop(crcs_pkg::PC_REL, 1'b0, 12'h000, 8'h05);
        chk(pc, 12'h005, "branch fwd");
        pcop(crcs_pkg::PC_REL, 1'b0, 12'h000, 8'hfe);
        chk(pc, 12'h003, "branch back");
        // Seven nested calls: the first return address falls off the bottom.
        pcop(crcs_pkg::PC_JUMP, 1'b0, 12'h100, 8'h00);
        for (int i = 0; i < 7; i++) begin
            pcop(crcs_pkg::PC_CALL, 1'b0, 12'h200 + 12'(i), 8'h00);
            chk(pc, 12'h200 + 12'(i), "call");
            chk(stack_level, (i < 5) ? 12'(i + 1) : 12'h006, "push level");
        end
        for (int i = 0; i < 6; i++) begin
            pcop(crcs_pkg::PC_RET, 1'b0, 12'h000, 8'h00);
            chk(pc, 12'h205 - 12'(i), "return");
            chk(stack_level, 12'(5 - i), "pop level");
        end
        pcop(crcs_pkg::PC_RET, 1'b0, 12'h000, 8'h00);
        chk(pc, 12'h201, "empty return");
        chk(stack_level, 12'h000, "empty level");
        // Banked flags across interrupt and non-maskable entry from, and return to, the normal context.
        flop(crcs_pkg::FL_ARITH, 1'b1, 8'h00, 1'b0);
        flags(1'b1, 1'b1, crcs_pkg::CTX_NMI);
        pcop(crcs_pkg::PC_RET, 1'b1, 12'h000, 8'h00);
        flags(1'b0, 1'b0, crcs_pkg::CTX_NORMAL);
        flop(crcs_pkg::FL_ARITH, 1'b0, 8'h05, 1'b0);
        flags(1'b0, 1'b0, crcs_pkg::CTX_NORMAL);
        flop(crcs_pkg::FL_LOGIC, 1'b1, 8'h00, 1'b0);
        flags(1'b0, 1'b1, crcs_pkg::CTX_NORMAL);
        u_bus.rd(8'hff, saved, hitv);
        pcop(crcs_pkg::PC_IRQ, 1'b0, 12'h004, 8'h00);
        flags(1'b0, 1'b0, crcs_pkg::CTX_IRQ);
        chk(pc, 12'h004, "irq vector");
        flop(crcs_pkg::FL_BITTEST, 1'b0, 8'h00, 1'b1);
        flags(1'b1, 1'b0, crcs_pkg::CTX_IRQ);
        chk(rotl_result, 8'h79, "rotate");
        u_bus.wr(8'hff, 8'h00);
        u_bus.wr(8'hff, saved);
        pcop(crcs_pkg::PC_RET, 1'b1, 12'h000, 8'h00);
        flags(1'b0, 1'b1, crcs_pkg::CTX_NORMAL);
        chk(pc, 12'h202, "irq return");
        chk(acc, 8'h3c, "acc restored");
        pcop(crcs_pkg::PC_NMI, 1'b0, 12'h008, 8'h00);
        flags(1'b1, 1'b1, crcs_pkg::CTX_NMI);
        flop(crcs_pkg::FL_ARITH, 1'b0, 8'h01, 1'b0);
        flags(1'b0, 1'b0, crcs_pkg::CTX_NMI);
        pcop(crcs_pkg::PC_RET, 1'b1, 12'h000, 8'h00);
        flags(1'b0, 1'b1, crcs_pkg::CTX_NORMAL);
        chk(pc, 12'h202, "nmi return");
        // Call and return on consecutive edges, with no hold cycle between them.
        @(negedge clk);
        pc_cmd = '{crcs_pkg::PC_CALL, 1'b0, 12'h300, 8'h00};
        @(negedge clk);
        chk(pc, 12'h300, "back-to-back call");
        pc_cmd.op = crcs_pkg::PC_RET;
        @(negedge clk);
        pc_cmd.op = crcs_pkg::PC_HOLD;
        chk(pc, 12'h202, "back-to-back return");
        chk(stack_level, 12'h000, "back-to-back level");
        // A mid-run reset must clear the normal pair as well as the active one, held over two edges.
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(pc, 12'h000, "pc after second reset");
        chk(stack_level, 12'h000, "level after second reset");
        flags(1'b0, 1'b0, crcs_pkg::CTX_NMI);
        rdchk(8'hff, 8'h00, 1'b1);
        pcop(crcs_pkg::PC_RET, 1'b1, 12'h000, 8'h00);
        flags(1'b0, 1'b0, crcs_pkg::CTX_NORMAL);
        chk(pc, 12'h001, "empty return after reset");
        final_report;
    end
endmodule
